// ==== dv/testbench.sv ====
// self-checking bench of the slave controller
// assumes the far model drives all trigger and channel lines
`timescale 1ns/1ps

module testbench;
    import tsmtc_pkg::*;
    logic        clk_sys = 1'b0, rst_n = 1'b0, counterRunBit = 1'b0, lag = 1'b0;
    logic        wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
    logic [7:0]  wb_adr_i = '0, want = '0;
    logic [3:0]  wb_sel_i = '0, internalTrigger;
    logic [31:0] wb_dat_i = '0, wb_dat_o, rdData;
    logic [15:0] ctrlNow = '0;
    logic        wb_ack_o, cntTick, cntDown, cntReinit, updateGen, cntStart, syncEnable;
    logic        triggerInput, ch1EdgeDetect, ch1FilteredInput, ch2FilteredInput;
    logic        externalTriggerPin;
    int          errors = 0, total_checks = 0, cnt[4] = '{default: 0}, base[4];

    tsmtc_slave_ctrl u_tsmtc_slave_ctrl (.clk_sys, .rst_n, .wb_cyc_i, .wb_stb_i, .wb_we_i,
        .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .internalTrigger,
        .ch1FilteredInput, .ch2FilteredInput, .ch1EdgeDetect, .externalTriggerPin,
        .counterRunBit, .cntTick, .cntDown, .cntReinit, .updateGen, .cntStart,
        .syncEnable, .triggerInput);
    tsmtc_far_model u_tsmtc_far_model (.clk_sys, .lag, .want, .internalTrigger,
        .ch1EdgeDetect, .ch1FilteredInput, .ch2FilteredInput, .externalTriggerPin);

    ////////////////////////////////////////////////////////////////////////////
    // clock and event counters
    always #50 clk_sys = ~clk_sys;

    always @(posedge clk_sys)
    begin
        cnt[0] <= cnt[0] + int'(cntTick === 1'b1);
        cnt[1] <= cnt[1] + int'(cntReinit === 1'b1);
        cnt[2] <= cnt[2] + int'(updateGen === 1'b1);
        cnt[3] <= cnt[3] + int'(cntStart === 1'b1);
    end

    ////////////////////////////////////////////////////////////////////////////
    // tasks
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        total_checks++;
        if (got !== exp)
        begin
            errors++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    // classic cycle: hold until ack, then idle a cycle
    task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] dat);
        int n = 0;
        @(posedge clk_sys);
        {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_sel_i, wb_dat_i} <= {2'b11, we, adr, 4'h3, dat};
        do
        begin
            @(posedge clk_sys);
            n++;
        end
        while (wb_ack_o !== 1'b1 && n < 20);
        chk("wb ack", 1'b1, wb_ack_o);
        rdData = wb_dat_o;
        {wb_cyc_i, wb_stb_i, wb_we_i} <= 3'b000;
        @(posedge clk_sys);
    endtask : wb

    task automatic rdchk(input string what, input logic [7:0] adr, input logic [31:0] exp);
        wb(1'b0, adr, '0);
        chk(what, exp, rdData);
    endtask : rdchk

    // slave off while the source moves, then the mode
    task automatic cfg(input logic [15:0] v);
        wb(1'b1, SMC_OFFSET, {16'h0000, ctrlNow & 16'hfff8});
        wb(1'b1, SMC_OFFSET, {16'h0000, v & 16'hfff8});
        wb(1'b1, SMC_OFFSET, {16'h0000, v});
        ctrlNow = v;
        repeat (8) @(posedge clk_sys);
    endtask : cfg

    task automatic pulse(input int idx, input int n, input int w);
        repeat (n)
        begin
            @(posedge clk_sys);
            want[idx] <= 1'b1;
            repeat (w) @(posedge clk_sys);
            want[idx] <= 1'b0;
            repeat (w) @(posedge clk_sys);
        end
        repeat (8) @(posedge clk_sys);
    endtask : pulse

    task automatic level(input int idx, input logic v);
        @(posedge clk_sys);
        want[idx] <= v;
        repeat (8) @(posedge clk_sys);
    endtask : level

    task automatic mark;
        @(negedge clk_sys);
        base = cnt;
    endtask : mark

    task automatic evt(input string what, input int k, input int exp);
        @(negedge clk_sys);
        chk(what, base[k] + exp, cnt[k]);
    endtask : evt

    task automatic win(input string what, input int exp);
        mark;
        repeat (10) @(posedge clk_sys);
        evt(what, 0, exp);
    endtask : win

    task automatic print_verdict;
        $display("checks %0d errors %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : print_verdict

    ////////////////////////////////////////////////////////////////////////////
    // scenarios
    initial
    begin
        repeat (5) @(posedge clk_sys);
        {rst_n, counterRunBit} <= 2'b11;
        rdchk("control reset", SMC_OFFSET, 32'h0);
        wb(1'b1, SMC_OFFSET, 32'h0000_fff8);
        rdchk("control rw", SMC_OFFSET, 32'h0000_fff0);
        chk("sync on", 1'b1, syncEnable);
        rdchk("unmapped", 8'h40, 32'h0);
        wb(1'b1, SMC_OFFSET, 32'h0);
        chk("sync off", 1'b0, syncEnable);
        $display("test registers done");
        win("free run", 10);
        @(posedge clk_sys) counterRunBit <= 1'b0;
        repeat (3) @(posedge clk_sys);
        win("run bit low", 0);
        @(posedge clk_sys) counterRunBit <= 1'b1;
        $display("test internal clock done");
        for (int s = 0; s < 8; s++)
        begin
            lag <= s[0];
            cfg(16'((s << 4) | 7)); // source moved with slave off
            mark;
            pulse(s, 1, 4);
            evt("source tick", 0, 1);
        end
        lag <= 1'b0;
        $display("test sources done");
        for (int m = 1; m < 4; m++)
        begin
            cfg(16'(m));
            mark;
            pulse(m == 1 ? 6 : 5, 2, 4);
            evt("encoder ticks", 0, 4);
            chk("encoder dir", 32'(m != 1), cntDown);
        end
        $display("test encoders done");
        cfg(16'h0014);
        mark;
        pulse(1, 2, 4);
        evt("reinit", 1, 2);
        evt("update", 2, 2);
        cfg(16'h0016);
        mark;
        pulse(1, 1, 4);
        evt("start", 3, 1);
        cfg(16'h0015);
        level(1, 1'b1);
        chk("trigger copy", 1'b1, triggerInput);
        win("gate open", 10);
        rdchk("status", STAT_OFFSET, 32'h19);
        level(1, 1'b0);
        win("gate shut", 0);
        mark;
        level(1, 1'b1);
        evt("gate no reinit", 1, 0);
        level(1, 1'b0);
        $display("test trigger modes done");
        for (int p = 0; p < 4; p++)
        begin
            cfg(16'((p << 12) | 16'h0077));
            mark;
            pulse(7, 8, 4);
            evt("prescaler", 0, 8 >> p);
        end
        for (int f = 0; f < 2; f++)
        begin
            cfg(f ? 16'h0f77 : 16'h0377);
            mark;
            pulse(7, 1, f ? 200 : 4);
            evt("filter short", 0, 0);
            mark;
            pulse(7, 1, f ? 300 : 12);
            evt("filter long", 0, 1);
            repeat (320) @(posedge clk_sys);
        end
        cfg(16'h8077);
        mark;
        level(7, 1'b1);
        evt("inverted rise", 0, 0);
        mark;
        level(7, 1'b0);
        evt("inverted fall", 0, 1);
        $display("test external path done");
        cfg(16'h4000);
        mark;
        pulse(7, 2, 4);
        evt("clock mode 2", 0, 2);
        cfg(16'h4007);
        mark;
        pulse(0, 1, 4);
        pulse(7, 1, 4);
        evt("both clock modes", 0, 1);
        cfg(16'h4005); // gate on internal trigger 0, never the pin
        level(0, 1'b1);
        mark;
        pulse(7, 2, 4);
        evt("gated clock 2", 0, 2);
        $display("test clock mode 2 done");
        print_verdict;
    end

    // watchdog, ten times the expected run
    initial
    begin
        repeat (30000) @(posedge clk_sys);
        errors++;
        print_verdict;
    end
endmodule : testbench

// ==== dv/tsmtc_far_model.sv ====
// far side stand-in: other timers' triggers, channel inputs, external pin
// assumes wanted levels set on clk_sys edges; lag adds a cycle
`timescale 1ns/1ps

module tsmtc_far_model (
    input  wire logic       clk_sys,
    input  wire logic       lag,
    input  wire logic [7:0] want,
    output logic      [3:0] internalTrigger,
    output logic            ch1EdgeDetect,
    output logic            ch1FilteredInput,
    output logic            ch2FilteredInput,
    output logic            externalTriggerPin
);
    logic [7:0] stage_q;
    logic [7:0] drive_q;

    // levels move only after an edge; pin held >= 4 cycles, below clock/4
    always_ff @(posedge clk_sys)
    begin
        stage_q <= want;
        drive_q <= lag ? stage_q : want;
    end

    // bit order matches the trigger source codes
    assign {externalTriggerPin, ch2FilteredInput, ch1FilteredInput, ch1EdgeDetect,
            internalTrigger} = drive_q;
endmodule : tsmtc_far_model

// ==== pkg/tsmtc_ext_if.sv ====
// carrier between the controller and the trigger conditioner: settings out, prescaled and filtered levels back
// assumes both ends sit on clk_sys
`timescale 1ns/1ps

interface tsmtc_ext_if;
    logic       polarity;
    logic [1:0] prescaleCfg;
    logic [3:0] filterCfg;
    logic       prescaled;
    logic       filtered;

    modport ctrl (output polarity, prescaleCfg, filterCfg, input prescaled, filtered);
    modport cond (input polarity, prescaleCfg, filterCfg, output prescaled, filtered);
endinterface : tsmtc_ext_if

// ==== pkg/tsmtc_pkg.sv ====
// constants and types of the slave-mode trigger block
// assumes a 16-bit control register on a 32-bit wishbone slave
package tsmtc_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // bus map
    localparam int unsigned WB_AW       = 8;
    localparam logic [7:0]  SMC_OFFSET  = 8'h08;
    localparam logic [7:0]  STAT_OFFSET = 8'h20;
    localparam logic [15:0] SMC_RESET   = 16'h0000;
    localparam logic [15:0] SMC_WMASK   = 16'hfff7; // bit 3 reserved, reads zero

    ////////////////////////////////////////////////////////////////////////////
    // control field positions
    localparam int MODE_LSB = 0;
    localparam int SRC_LSB  = 4;
    localparam int SYNC_BIT = 7;
    localparam int FILT_LSB = 8;
    localparam int PSC_LSB  = 12;
    localparam int ECM2_BIT = 14;
    localparam int POL_BIT  = 15;

    // status field positions
    localparam int ST_TRIG_BIT = 0;
    localparam int ST_FILT_BIT = 1;
    localparam int ST_PSC_BIT  = 2;
    localparam int ST_DOWN_BIT = 3;
    localparam int ST_GATE_BIT = 4;

    ////////////////////////////////////////////////////////////////////////////
    // slave modes and trigger sources, in code order
    typedef enum logic [2:0] {
        SM_OFF, SM_ENC1, SM_ENC2, SM_ENC3, SM_RESET, SM_GATED, SM_TRIG, SM_EXT1
    } tsmtc_mode_t;

    typedef enum logic [2:0] {
        TS_INT0, TS_INT1, TS_INT2, TS_INT3,
        TS_CH1_EDGE, TS_CH1_FILT, TS_CH2_FILT, TS_EXT_FILT
    } tsmtc_src_t;

    // filter: log2 of sampling divider, agreeing sample count
    typedef struct packed {
        logic [2:0] divLog2;
        logic [3:0] count;
    } tsmtc_filt_t;

    function automatic tsmtc_filt_t tsmtc_filt_params(input logic [3:0] code);
        tsmtc_filt_t p;
        p = '{3'h0, 4'h1};
        unique case (code)
            4'h0: p = '{3'h0, 4'h1}; // no filter, every clock
            4'h1: p = '{3'h0, 4'h2};
            4'h2: p = '{3'h0, 4'h4};
            4'h3: p = '{3'h0, 4'h8};
            4'h4: p = '{3'h1, 4'h6};
            4'h5: p = '{3'h1, 4'h8};
            4'h6: p = '{3'h2, 4'h6};
            4'h7: p = '{3'h2, 4'h8};
            4'h8: p = '{3'h3, 4'h6};
            4'h9: p = '{3'h3, 4'h8};
            4'ha: p = '{3'h3, 4'h5};
            4'hb: p = '{3'h4, 4'h5};
            4'hc: p = '{3'h4, 4'h8};
            4'hd: p = '{3'h5, 4'h5};
            4'he: p = '{3'h5, 4'h6};
            4'hf: p = '{3'h5, 4'h8};
        endcase
        return p;
    endfunction : tsmtc_filt_params

endpackage : tsmtc_pkg

// ==== rtl/tsmtc_edge_det.sv ====
// rise and fall detector for synchronous levels
// assumes the inputs already belong to clk_sys
`timescale 1ns/1ps

module tsmtc_edge_det #(
    parameter int W = 1
) (
    input  wire logic         clk_sys,
    input  wire logic         rst_n,
    input  wire logic [W-1:0] level,
    output logic      [W-1:0] rise,
    output logic      [W-1:0] fall
);
    logic [W-1:0] prev_q;
    logic [W-1:0] prev_d;

    ////////////////////////////////////////////////////////////////////////////
    // edges come from the previous registered sample
    always_comb
    begin
        prev_d = level;
        rise   = level & ~prev_q; // [RQ20]
        fall   = ~level & prev_q;
    end

    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
            prev_q <= '0;
        else
            prev_q <= prev_d;
    end
endmodule : tsmtc_edge_det

// ==== rtl/tsmtc_ext_cond.sv ====
// external trigger path: synchroniser, polarity, prescaler, digital filter
// assumes an asynchronous pin, under clk_sys/4 after division
`timescale 1ns/1ps

module tsmtc_ext_cond (
    input  wire logic   clk_sys,
    input  wire logic   rst_n,
    input  wire logic   externalTriggerPin,
    tsmtc_ext_if.cond   ext
);
    import tsmtc_pkg::*;

    logic       sync1_q, sync2_q;
    logic       polPrev_q, polPrev_d;
    logic [2:0] pscCnt_q, pscCnt_d;
    logic [4:0] divCnt_q, divCnt_d;
    logic [3:0] agree_q, agree_d;
    logic       filt_q, filt_d;
    logic       polLevel;
    logic       pscLevel;
    logic [4:0] divMask;
    logic       sampleEn;
    tsmtc_filt_t fp;

    ////////////////////////////////////////////////////////////////////////////
    // two-flop synchroniser, first stage feeds only the second
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            sync1_q <= 1'b0;
            sync2_q <= 1'b0;
        end
        else
        begin
            sync1_q <= externalTriggerPin; // [RQ20]
            sync2_q <= sync1_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // polarity, edge-count prescaler, then sample-and-agree filter
    always_comb
    begin
        fp        = tsmtc_filt_params(ext.filterCfg); // [RQ12]
        polLevel  = sync2_q ^ ext.polarity; // [RQ19]
        polPrev_d = polLevel;
        pscCnt_d  = pscCnt_q;
        if (polLevel && !polPrev_q)
            pscCnt_d = pscCnt_q + 3'h1;
        // bit k of the edge count runs at f/2^(k+1)
        unique case (ext.prescaleCfg)
            2'h0: pscLevel = polLevel; // [RQ14]
            2'h1: pscLevel = pscCnt_q[0];
            2'h2: pscLevel = pscCnt_q[1];
            2'h3: pscLevel = pscCnt_q[2];
        endcase
        divMask  = ~(5'h1f << fp.divLog2);
        sampleEn = (divCnt_q & divMask) == divMask;
        divCnt_d = divCnt_q + 5'h1;
        agree_d  = agree_q;
        filt_d   = filt_q;
        if (sampleEn)
        begin
            if (pscLevel != filt_q)
            begin
                // flip only after n disagreeing samples
                if (agree_q + 4'h1 >= fp.count) // [RQ13]
                begin
                    filt_d  = pscLevel;
                    agree_d = 4'h0;
                end
                else
                    agree_d = agree_q + 4'h1;
            end
            else
                agree_d = 4'h0;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            polPrev_q <= 1'b0;
            pscCnt_q  <= 3'h0;
            divCnt_q  <= 5'h0;
            agree_q   <= 4'h0;
            filt_q    <= 1'b0;
        end
        else
        begin
            polPrev_q <= polPrev_d;
            pscCnt_q  <= pscCnt_d;
            divCnt_q  <= divCnt_d;
            agree_q   <= agree_d;
            filt_q    <= filt_d;
        end
    end

    assign ext.prescaled = pscLevel;
    assign ext.filtered  = filt_q;
endmodule : tsmtc_ext_cond

// ==== rtl/tsmtc_slave_ctrl.sv ====
// slave-mode controller: wishbone register, trigger source mux, count engine
// assumes an outside counter core acts on the count pulses
//
// Register access over Wishbone and the register addresses were decided locally.
`timescale 1ns/1ps

// Summary of operation
// RQ1 - mode 000: no slave control; run bit lets internal clock count
// RQ2 - encoder 1: count on channel 2 edges, channel 1 level sets direction
// RQ3 - encoder 2: count on channel 1 edges, channel 2 level sets direction
// RQ4 - encoder 3: count on both channel edges, other level sets direction
// RQ5 - reset mode: trigger rising edge reinitialises counter and requests update
// RQ6 - gated mode: count while trigger high, pause while low, never reset
// RQ7 - trigger mode: trigger rising edge starts the counter
// RQ8 - external clock 1: each trigger rising edge is one count
// RQ9 - software changes trigger source only while mode is 000
// RQ10 - source field picks internal triggers, channel signals or filtered pin
// RQ11 - bit 7 turns master/slave synchronisation on
// RQ12 - filter field picks divider and count pairs, zero means unfiltered
// RQ13 - filter samples at clock over divider, flips after n agreeing samples
// RQ14 - prescaler passes, or divides the pin by 2, 4 or 8
// RQ15 - software keeps prescaled pin below a quarter of the clock
// RQ16 - external clock 2 counts on filtered pin edges
// RQ17 - with clock mode 2 plus slave mode, source must not be the pin
// RQ18 - both clock modes on: filtered pin is the count clock
// RQ19 - polarity bit inverts the pin before prescaler and filter
// RQ20 - pin synchronised, trigger edges found from registered samples
module tsmtc_slave_ctrl (
    input  wire logic                         clk_sys,
    input  wire logic                         rst_n,
    input  wire logic                         wb_cyc_i,
    input  wire logic                         wb_stb_i,
    input  wire logic                         wb_we_i,
    input  wire logic [tsmtc_pkg::WB_AW-1:0]  wb_adr_i,
    input  wire logic [3:0]                   wb_sel_i,
    input  wire logic [31:0]                  wb_dat_i,
    output logic      [31:0]                  wb_dat_o,
    output logic                              wb_ack_o,
    input  wire logic [3:0]                   internalTrigger,
    input  wire logic                         ch1FilteredInput,
    input  wire logic                         ch2FilteredInput,
    input  wire logic                         ch1EdgeDetect,
    input  wire logic                         externalTriggerPin,
    input  wire logic                         counterRunBit,
    output logic                              cntTick,
    output logic                              cntDown,
    output logic                              cntReinit,
    output logic                              updateGen,
    output logic                              cntStart,
    output logic                              syncEnable,
    output logic                              triggerInput
);
    import tsmtc_pkg::*;

    logic [15:0]  smc_q, smc_d;
    logic         ack_q, ack_d;
    logic [31:0]  dat_q, dat_d;
    logic         tick_q, tick_d;
    logic         down_q, down_d;
    logic         reinit_q, reinit_d;
    logic         upd_q, upd_d;
    logic         start_q, start_d;
    logic         gate_q, gate_d;
    logic         trig_q, trig_d;
    logic         busReq;
    logic         trigLevel;
    logic         trigRise;
    logic         extRise;
    logic [1:0]   chRise, chFall, chEdge;
    logic         countEdge;
    logic         baseTick;
    tsmtc_mode_t  mode;
    tsmtc_src_t   src;
    logic         ecm2;
    logic [15:0]  status;
    logic [15:0]  wrMask;
    tsmtc_ext_if  extBus ();

    ////////////////////////////////////////////////////////////////////////////
    // field views of the control register
    assign mode = tsmtc_mode_t'(smc_q[MODE_LSB +: 3]);
    assign src  = tsmtc_src_t'(smc_q[SRC_LSB +: 3]);
    assign ecm2 = smc_q[ECM2_BIT];
    assign extBus.polarity    = smc_q[POL_BIT]; // [RQ19]
    assign extBus.prescaleCfg = smc_q[PSC_LSB +: 2];
    assign extBus.filterCfg   = smc_q[FILT_LSB +: 4];

    tsmtc_ext_cond u_ext (
        .clk_sys            (clk_sys),
        .rst_n              (rst_n),
        .externalTriggerPin (externalTriggerPin),
        .ext                (extBus)
    );

    ////////////////////////////////////////////////////////////////////////////
    // trigger source mux; a live change can fake an edge, hence mode 000 only
    always_comb
    begin
        unique case (src)
            TS_INT0:     trigLevel = internalTrigger[0]; // [RQ10]
            TS_INT1:     trigLevel = internalTrigger[1];
            TS_INT2:     trigLevel = internalTrigger[2];
            TS_INT3:     trigLevel = internalTrigger[3];
            TS_CH1_EDGE: trigLevel = ch1EdgeDetect;
            TS_CH1_FILT: trigLevel = ch1FilteredInput;
            TS_CH2_FILT: trigLevel = ch2FilteredInput;
            TS_EXT_FILT: trigLevel = extBus.filtered;
        endcase
    end

    // edges of the trigger, both channels and the filtered pin
    tsmtc_edge_det #(.W(1)) u_trig_edge (
        .clk_sys (clk_sys),
        .rst_n   (rst_n),
        .level   (trigLevel),
        .rise    (trigRise),
        .fall    ()
    );

    tsmtc_edge_det #(.W(2)) u_ch_edge (
        .clk_sys (clk_sys),
        .rst_n   (rst_n),
        .level   ({ch2FilteredInput, ch1FilteredInput}),
        .rise    (chRise),
        .fall    (chFall)
    );

    tsmtc_edge_det #(.W(1)) u_ext_edge (
        .clk_sys (clk_sys),
        .rst_n   (rst_n),
        .level   (extBus.filtered),
        .rise    (extRise),
        .fall    ()
    );

    assign chEdge = chRise | chFall;

    ////////////////////////////////////////////////////////////////////////////
    // count engine: one pulse per count, direction held between counts
    always_comb
    begin
        tick_d   = 1'b0;
        down_d   = down_q;
        reinit_d = 1'b0;
        upd_d    = 1'b0;
        start_d  = 1'b0;
        gate_d   = 1'b0;
        trig_d   = trigLevel;
        // clock mode 2 counts filtered pin edges
        baseTick  = ecm2 ? extRise : 1'b1; // [RQ16]
        countEdge = ecm2 ? extRise : trigRise; // [RQ18]
        unique case (mode)
            SM_OFF:
                tick_d = counterRunBit & baseTick; // [RQ1]
            SM_ENC1:
            begin
                tick_d = counterRunBit & chEdge[1]; // [RQ2]
                if (chEdge[1])
                    down_d = ch2FilteredInput != ch1FilteredInput;
            end
            SM_ENC2:
            begin
                tick_d = counterRunBit & chEdge[0]; // [RQ3]
                if (chEdge[0])
                    down_d = ch1FilteredInput == ch2FilteredInput;
            end
            SM_ENC3:
            begin
                // simultaneous edges are not quadrature; channel 1 wins
                tick_d = counterRunBit & (chEdge[0] | chEdge[1]); // [RQ4]
                if (chEdge[0])
                    down_d = ch1FilteredInput == ch2FilteredInput;
                else if (chEdge[1])
                    down_d = ch2FilteredInput != ch1FilteredInput;
            end
            SM_RESET:
            begin
                tick_d   = counterRunBit & baseTick & ~trigRise;
                reinit_d = trigRise; // [RQ5]
                upd_d    = trigRise;
            end
            SM_GATED:
            begin
                gate_d = trigLevel; // [RQ6]
                tick_d = counterRunBit & baseTick & trigLevel;
            end
            SM_TRIG:
            begin
                start_d = trigRise; // [RQ7]
                tick_d  = counterRunBit & baseTick;
            end
            SM_EXT1:
                tick_d = counterRunBit & countEdge; // [RQ8]
        endcase
    end

    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            tick_q   <= 1'b0;
            down_q   <= 1'b0;
            reinit_q <= 1'b0;
            upd_q    <= 1'b0;
            start_q  <= 1'b0;
            gate_q   <= 1'b0;
            trig_q   <= 1'b0;
        end
        else
        begin
            tick_q   <= tick_d;
            down_q   <= down_d;
            reinit_q <= reinit_d;
            upd_q    <= upd_d;
            start_q  <= start_d;
            gate_q   <= gate_d;
            trig_q   <= trig_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // wishbone slave: ack a cycle after strobe, write lands a cycle after ack, as ack drops
    assign busReq = wb_cyc_i & wb_stb_i;
    assign wrMask = {{8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}} & SMC_WMASK;

    always_comb
    begin
        status = 16'h0000;
        status[ST_TRIG_BIT] = trig_q;
        status[ST_FILT_BIT] = extBus.filtered;
        status[ST_PSC_BIT]  = extBus.prescaled;
        status[ST_DOWN_BIT] = down_q;
        status[ST_GATE_BIT] = gate_q;
        smc_d = smc_q;
        ack_d = busReq & ~ack_q;
        dat_d = 32'h0000_0000; // unmapped addresses read zero
        if (busReq && !ack_q && !wb_we_i)
        begin
            if (wb_adr_i[7:2] == SMC_OFFSET[7:2])
                dat_d = {16'h0000, smc_q};
            else if (wb_adr_i[7:2] == STAT_OFFSET[7:2])
                dat_d = {16'h0000, status};
        end
        if (busReq && ack_q && wb_we_i && wb_adr_i[7:2] == SMC_OFFSET[7:2])
            smc_d = (smc_q & ~wrMask) | (wb_dat_i[15:0] & wrMask);
    end

    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            smc_q <= SMC_RESET;
            ack_q <= 1'b0;
            dat_q <= 32'h0000_0000;
        end
        else
        begin
            smc_q <= smc_d;
            ack_q <= ack_d;
            dat_q <= dat_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // outputs, each straight from a flop
    assign wb_ack_o     = ack_q;
    assign wb_dat_o     = dat_q;
    assign cntTick      = tick_q;
    assign cntDown      = down_q;
    assign cntReinit    = reinit_q;
    assign updateGen    = upd_q;
    assign cntStart     = start_q;
    assign syncEnable   = smc_q[SYNC_BIT]; // [RQ11]
    assign triggerInput = trig_q;

    ////////////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);

    sequence s_reset_edge;
        mode == SM_RESET && trigRise;
    endsequence

    sequence s_reinit_pulse;
        reinit_q && upd_q ##1 !reinit_q;
    endsequence

    property p_off_tick;
        mode == SM_OFF && !ecm2 && counterRunBit |=> tick_q;
    endproperty
    a_off_tick: assert property (p_off_tick) else $error("no internal tick"); // [RQ1]

    property p_enc1;
        mode == SM_ENC1 && counterRunBit && $stable(mode) |=> tick_q == $past(chEdge[1]);
    endproperty
    a_enc1: assert property (p_enc1) else $error("enc1 tick wrong"); // [RQ2]

    property p_enc2;
        mode == SM_ENC2 && counterRunBit && chRise[0] && !ch2FilteredInput |=> tick_q && !down_q;
    endproperty
    a_enc2: assert property (p_enc2) else $error("enc2 direction wrong"); // [RQ3]

    property p_enc3;
        mode == SM_ENC3 && !counterRunBit |=> !tick_q;
    endproperty
    a_enc3: assert property (p_enc3) else $error("enc3 counted while stopped"); // [RQ4]

    property p_reset_mode;
        s_reset_edge |=> s_reinit_pulse;
    endproperty
    a_reset_mode: assert property (p_reset_mode) else $error("no reinit"); // [RQ5]

    property p_gated;
        mode == SM_GATED && !trigLevel |=> !tick_q && !reinit_q && !gate_q;
    endproperty
    a_gated: assert property (p_gated) else $error("gate leaked"); // [RQ6]

    property p_trig_start;
        mode == SM_TRIG && trigRise |=> start_q ##1 !start_q;
    endproperty
    a_trig_start: assert property (p_trig_start) else $error("no start"); // [RQ7]

    property p_ext1;
        mode == SM_EXT1 && !ecm2 && counterRunBit |=> tick_q == $past(trigRise);
    endproperty
    a_ext1: assert property (p_ext1) else $error("ext1 tick wrong"); // [RQ8]

    property p_ecm2;
        ecm2 && (mode == SM_OFF || mode == SM_EXT1) && counterRunBit
            |=> tick_q == $past(extRise);
    endproperty
    a_ecm2: assert property (p_ecm2) else $error("ext2 tick wrong"); // [RQ18]

    property p_src_ext;
        src == TS_EXT_FILT |-> trigLevel == extBus.filtered;
    endproperty
    a_src_ext: assert property (p_src_ext) else $error("source mux wrong"); // [RQ10]

    property p_ack;
        busReq && !ack_q |=> ack_q ##1 !ack_q;
    endproperty
    a_ack: assert property (p_ack) else $error("ack timing wrong");

endmodule : tsmtc_slave_ctrl
